// ### rtl/plut_pkg.sv
// Constants shared by the protection table lockdown block
package plut_pkg;
  // Table geometry
  localparam int          PLUT_DEPTH      = 16;
  localparam int          PLUT_IDX_W      = 4;
  localparam int          PLUT_DATA_W     = 32;
  localparam int          PLUT_LANES      = 4;
  localparam logic [3:0]  PLUT_LAST_INDEX = 4'hF;
  // Control word field positions
  localparam int          PLUT_AUTOINC_BIT = 8;
  localparam int          PLUT_LOCK_BIT    = 31;
  // Values after reset
  localparam logic        PLUT_AUTOINC_RST = 1'h0;
  localparam logic        PLUT_LOCK_RST    = 1'h0;
  localparam logic        PLUT_INTEN_RST   = 1'h0;
  localparam logic [3:0]  PLUT_IDX_RST     = 4'h0;
  localparam logic [31:0] PLUT_ENTRY_RST   = 32'h0000_0000;
  localparam logic [31:0] PLUT_RDATA_RST   = 32'h0000_0000;
  // Reset synchroniser depth
  localparam int          PLUT_SYNC_STAGES = 2;
endpackage

// ### rtl/plut_rst_sync.sv
// Reset synchroniser: asynchronous assert, two-flop release
`timescale 1ns/1ns
`default_nettype none
module plut_rst_sync
  import plut_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  output var  logic rstSync_n
);
  logic [PLUT_SYNC_STAGES-1:0] stage;
  logic [PLUT_SYNC_STAGES-1:0] next_stage;

  // Shift a one in after release
  always_comb begin
    next_stage = {stage[PLUT_SYNC_STAGES-2:0], 1'b1};
  end

  // Register the chain
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= '0;
    end else begin
      stage <= next_stage;
    end
  end

  assign rstSync_n = stage[PLUT_SYNC_STAGES-1];
endmodule
`default_nettype wire

// ### rtl/plut_lockdown.sv
// Protection look-up table access logic with configuration lockdown
//
// What this block does
// RULE1 - Control bit 8 makes data accesses step index
// RULE2 - Readable last valid table index for traversal
// RULE3 - Index write selects entry for later accesses
// RULE4 - Software dumps table from index zero, autoincrementing
// RULE5 - Data write stores word into indexed entry
// RULE6 - Byte writes change only enabled bytes
// RULE7 - Writing one to control bit 31 locks configuration
// RULE8 - Lockdown clears only by reset, never by software
// RULE9 - Locked: control, table, interrupt enable ignore writes
// RULE10 - Locked: table reads and index stepping still work
// RULE11 - Software should set autoincrement before locking
// RULE12 - Without autoincrement, data accesses keep the index
`timescale 1ns/1ns
`default_nettype none
module plut_lockdown
  import plut_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  input  wire logic                    ctrlWrEn,
  input  wire logic [PLUT_DATA_W-1:0]  ctrlWrData,
  input  wire logic                    intEnWrEn,
  input  wire logic                    intEnWrData,
  input  wire logic                    idxWrEn,
  input  wire logic [PLUT_IDX_W-1:0]   idxWrData,
  input  wire logic                    dataWrEn,
  input  wire logic [PLUT_LANES-1:0]   dataByteEn,
  input  wire logic [PLUT_DATA_W-1:0]  dataWrData,
  input  wire logic                    dataRdEn,
  input  wire logic [PLUT_IDX_W-1:0]   lookupIdx,
  output var  logic [PLUT_DATA_W-1:0]  dataRdData,
  output var  logic [PLUT_DATA_W-1:0]  lookupWord,
  output var  logic [PLUT_IDX_W-1:0]   tableIndex,
  output var  logic [PLUT_IDX_W-1:0]   tableLastIndex,
  output var  logic                    autoIncEnable,
  output var  logic                    lockdown,
  output var  logic                    intEnable
);
  // ==========================================================
  // Reset release
  logic rstSync_n;

  plut_rst_sync u_rst_sync (
    .clk       (clk),
    .arst_n    (arst_n),
    .rstSync_n (rstSync_n)
  );

  // ==========================================================
  // Control, interrupt enable and index
  logic                  next_autoIncEnable;
  logic                  next_lockdown;
  logic                  next_intEnable;
  logic [PLUT_IDX_W-1:0] next_tableIndex;
  logic                  dataAccess;
  logic                  tableWrite;

  assign dataAccess = dataWrEn | dataRdEn;
  assign tableWrite = dataWrEn & ~lockdown; // RULE9

  // Next control state; locked writes are dropped
  always_comb begin
    next_autoIncEnable = autoIncEnable;
    next_lockdown      = lockdown;
    next_intEnable     = intEnable;
    if (ctrlWrEn && !lockdown) begin // RULE9
      next_autoIncEnable = ctrlWrData[PLUT_AUTOINC_BIT]; // RULE1
      next_lockdown      = ctrlWrData[PLUT_LOCK_BIT]; // RULE7
    end
    if (intEnWrEn && !lockdown) begin // RULE9
      next_intEnable = intEnWrData;
    end
    // Once set only reset clears it
    if (lockdown) begin
      next_lockdown = 1'b1; // RULE8
    end
  end

  // Next index; an explicit load beats the auto step
  always_comb begin
    next_tableIndex = tableIndex;
    if (idxWrEn) begin
      next_tableIndex = idxWrData; // RULE3
    end else if (dataAccess && autoIncEnable) begin
      next_tableIndex = tableIndex + 4'h1; // RULE1 RULE10
    end
  end

  // Register control state
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      autoIncEnable <= PLUT_AUTOINC_RST;
      lockdown      <= PLUT_LOCK_RST; // RULE8
      intEnable     <= PLUT_INTEN_RST;
      tableIndex    <= PLUT_IDX_RST;
    end else begin
      autoIncEnable <= next_autoIncEnable;
      lockdown      <= next_lockdown;
      intEnable     <= next_intEnable;
      tableIndex    <= next_tableIndex; // RULE12
    end
  end

  assign tableLastIndex = PLUT_LAST_INDEX; // RULE2

  // ==========================================================
  // Table storage, one generate step per entry
  logic [PLUT_DATA_W-1:0] lutMem [PLUT_DEPTH];

  for (genvar e = 0; e < PLUT_DEPTH; e++) begin : g_entry
    logic [PLUT_DATA_W-1:0] next_entry;

    // Merge enabled byte lanes into the selected entry
    always_comb begin
      next_entry = lutMem[e];
      if (tableWrite && tableIndex == PLUT_IDX_W'(e)) begin // RULE5
        for (int b = 0; b < PLUT_LANES; b++) begin
          if (dataByteEn[b]) begin
            next_entry[8*b +: 8] = dataWrData[8*b +: 8]; // RULE6
          end
        end
      end
    end

    // Register the entry
    always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
        lutMem[e] <= PLUT_ENTRY_RST;
      end else begin
        lutMem[e] <= next_entry;
      end
    end
  end

  // ==========================================================
  // Read paths
  logic [PLUT_DATA_W-1:0] selWord;
  logic [PLUT_DATA_W-1:0] next_dataRdData;
  logic [PLUT_DATA_W-1:0] next_lookupWord;

  assign selWord = lutMem[tableIndex];

  // Software read holds its word; lookup follows every cycle
  always_comb begin
    next_dataRdData = dataRdData;
    if (dataRdEn) begin
      next_dataRdData = selWord; // RULE10
    end
    next_lookupWord = lutMem[lookupIdx];
  end

  // Register read data
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dataRdData <= PLUT_RDATA_RST;
      lookupWord <= PLUT_RDATA_RST;
    end else begin
      dataRdData <= next_dataRdData;
      lookupWord <= next_lookupWord;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstSync_n);

  a_lock_sticky: assert property (lockdown |=> lockdown[*8]) // RULE8
    else $error("lockdown dropped without reset");
  a_lock_set: assert property ( // RULE7
    ctrlWrEn && ctrlWrData[PLUT_LOCK_BIT] |=> lockdown)
    else $error("lockdown not set by control write");
  a_ctrl_frozen: assert property ( // RULE9
    lockdown && ctrlWrEn |=> $stable(autoIncEnable))
    else $error("control changed while locked");
  a_inten_frozen: assert property ( // RULE9
    lockdown && intEnWrEn |=> $stable(intEnable))
    else $error("interrupt enable changed while locked");
  a_table_frozen: assert property ( // RULE9
    lockdown && dataWrEn |=> lutMem[$past(tableIndex)] == $past(selWord))
    else $error("table changed while locked");
  a_idx_load: assert property ( // RULE3
    idxWrEn |=> tableIndex == $past(idxWrData))
    else $error("index not loaded");
  a_idx_step: assert property ( // RULE1
    !idxWrEn && autoIncEnable && dataAccess
    |=> tableIndex == PLUT_IDX_W'($past(tableIndex) + 4'h1))
    else $error("index did not advance");
  a_locked_step: assert property ( // RULE10
    lockdown && autoIncEnable && dataRdEn && !idxWrEn
    |=> tableIndex == PLUT_IDX_W'($past(tableIndex) + 4'h1))
    else $error("locked read did not advance index");
  a_idx_hold: assert property ( // RULE12
    !idxWrEn && !autoIncEnable |=> $stable(tableIndex))
    else $error("index moved without autoincrement");
  a_rd_word: assert property ( // RULE10
    dataRdEn && !dataWrEn
    |=> dataRdData == lutMem[$past(tableIndex)])
    else $error("read data wrong");
  a_byte_store: assert property ( // RULE5
    !lockdown && dataWrEn && dataByteEn[0]
    |=> lutMem[$past(tableIndex)][7:0] == $past(dataWrData[7:0]))
    else $error("byte lane 0 not stored");
  a_byte_keep: assert property ( // RULE6
    !lockdown && dataWrEn && !dataByteEn[3]
    |=> lutMem[$past(tableIndex)][31:24] == $past(selWord[31:24]))
    else $error("disabled byte lane changed");
  a_last_index: assert property ( // RULE2
    tableLastIndex == PLUT_IDX_W'(PLUT_DEPTH - 1))
    else $error("last index wrong");

  c_lock_set:    cover property (!lockdown ##1 lockdown);
  c_locked_read: cover property (lockdown && autoIncEnable && dataRdEn);
  c_byte_write:  cover property (tableWrite && dataByteEn == 4'h2);
  c_idx_wrap:    cover property (tableIndex == 4'hF ##1 tableIndex == 4'h0);
endmodule
`default_nettype wire

// ### tb/plut_lockdown_test.sv
// Self-checking bench for the protection table lockdown block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin badCount++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module plut_lockdown_test
  import plut_pkg::*;
;
  // ==========================================================
  // Stimulus and observed signals
  logic        clk = 1'h0, arst_n = 1'h0;
  logic        ctrlWrEn = 1'h0, intEnWrEn = 1'h0, intEnWrData = 1'h0;
  logic        idxWrEn = 1'h0, dataWrEn = 1'h0, dataRdEn = 1'h0;
  logic [31:0] ctrlWrData = 32'h0, dataWrData = 32'h0;
  logic [3:0]  idxWrData = 4'h0, dataByteEn = 4'h0, lookupIdx = 4'h0;
  logic [31:0] dataRdData, lookupWord, expWord [16];
  logic [3:0]  tableIndex, tableLastIndex;
  logic        autoIncEnable, lockdown, intEnable;
  int          badCount = 0, cmpCount = 0;
  plut_lockdown dut (.clk(clk), .arst_n(arst_n), .ctrlWrEn(ctrlWrEn),
    .ctrlWrData(ctrlWrData), .intEnWrEn(intEnWrEn),
    .intEnWrData(intEnWrData), .idxWrEn(idxWrEn), .idxWrData(idxWrData),
    .dataWrEn(dataWrEn), .dataByteEn(dataByteEn), .dataWrData(dataWrData),
    .dataRdEn(dataRdEn), .lookupIdx(lookupIdx), .dataRdData(dataRdData),
    .lookupWord(lookupWord), .tableIndex(tableIndex),
    .tableLastIndex(tableLastIndex), .autoIncEnable(autoIncEnable),
    .lockdown(lockdown), .intEnable(intEnable));
  // Clock at 100 MHz
  always #5 clk = ~clk;
  // ==========================================================
  // Access tasks: strobe for one edge, then let outputs settle
  task automatic wr_ctrl(input logic [31:0] v);
    @(posedge clk); ctrlWrEn <= 1'h1; ctrlWrData <= v;
    @(posedge clk); ctrlWrEn <= 1'h0; #1;
  endtask
  task automatic wr_inten(input logic v);
    @(posedge clk); intEnWrEn <= 1'h1; intEnWrData <= v;
    @(posedge clk); intEnWrEn <= 1'h0; #1;
  endtask
  task automatic wr_idx(input logic [3:0] v);
    @(posedge clk); idxWrEn <= 1'h1; idxWrData <= v;
    @(posedge clk); idxWrEn <= 1'h0; #1;
  endtask
  task automatic wr_data(input logic [3:0] be, input logic [31:0] v);
    @(posedge clk); dataWrEn <= 1'h1; dataByteEn <= be; dataWrData <= v;
    @(posedge clk); dataWrEn <= 1'h0; #1;
  endtask
  task automatic rd_data(input logic [31:0] e);
    @(posedge clk); dataRdEn <= 1'h1;
    @(posedge clk); dataRdEn <= 1'h0; #1;
    `CHK("read word", e, dataRdData)
  endtask
  task automatic done(input string nm);
    $display("test %s finished, mismatches so far %0d", nm, badCount);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    @(posedge clk);
    arst_n <= 1'h0;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    badCount++;
    wrap_up();
  end
  // ==========================================================
  // Test sequence
  initial begin
    do_reset();
    `CHK("last index", 4'hF, tableLastIndex)
    `CHK("index", 4'h0, tableIndex)
    `CHK("lock", 1'h0, lockdown)
    `CHK("autoinc", 1'h0, autoIncEnable)
    done("reset");
    // Fixed index: accesses keep the index
    wr_idx(4'h5);
    `CHK("index", 4'h5, tableIndex)
    wr_data(4'hF, 32'hCAFE_0055);
    `CHK("index", 4'h5, tableIndex)
    rd_data(32'hCAFE_0055);
    wr_data(4'h2, 32'h1111_3C22);
    rd_data(32'hCAFE_3C55);
    `CHK("index", 4'h5, tableIndex)
    done("fixed index");
    // Fill and dump with autoincrement
    wr_ctrl(32'h0000_0100);
    `CHK("autoinc", 1'h1, autoIncEnable)
    wr_idx(4'h0);
    for (int j = 0; j < 16; j++) begin
      expWord[j] = 32'h1020_3041 * (j + 1);
      wr_data(4'hF, expWord[j]);
      `CHK("index", 4'(j + 1), tableIndex)
    end
    wr_idx(4'h0);
    for (int j = 0; j <= 15; j++) rd_data(expWord[j]);
    for (int j = 0; j < 16; j++) begin
      @(posedge clk); lookupIdx <= 4'(j);
      @(posedge clk); #1;
      `CHK("lookup", expWord[j], lookupWord)
    end
    done("fill and dump");
    // Lockdown: control, enable and table writes refused, index loads, reads and stepping still work
    wr_inten(1'h1);
    `CHK("int enable", 1'h1, intEnable)
    wr_ctrl(32'h8000_0100);
    `CHK("lock", 1'h1, lockdown)
    wr_ctrl(32'h0000_0000);
    `CHK("lock", 1'h1, lockdown)
    `CHK("autoinc", 1'h1, autoIncEnable)
    wr_inten(1'h0);
    `CHK("int enable", 1'h1, intEnable)
    wr_idx(4'h2);
    wr_data(4'hF, 32'hDEAD_BEEF);
    `CHK("index", 4'h3, tableIndex)
    wr_idx(4'h2);
    rd_data(expWord[2]);
    rd_data(expWord[3]);
    `CHK("index", 4'h4, tableIndex)
    done("lockdown");
    // Only a reset clears the lock
    do_reset();
    `CHK("lock", 1'h0, lockdown)
    `CHK("int enable", 1'h0, intEnable)
    done("reset clears lock");
    wrap_up();
  end
endmodule
`default_nettype wire
